//--- common/gxa_pkg.sv
package gxa_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ABORT = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // ctrl fields
  localparam int CTRL_POL_LSB = 0;
  localparam logic [1:0] POL_BEFORE = 2'h0;
  localparam logic [1:0] POL_AFTER = 2'h1;
  localparam logic [1:0] POL_ABORT = 2'h2;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_MON_BIT = 1;
  localparam int ST_NMI_BIT = 2;
  localparam int ST_SHUT_BIT = 3;
  localparam int ST_HALT_BIT = 4;
  // host control field bits
  localparam int CR4_EXT_BIT = 5;
  localparam int EXC_MC_BIT = 18;
  localparam logic [63:0] FLAGS_VAL = 64'h0000_0000_0000_0002;
  // list entry checks
  localparam logic [31:0] MSR_SEG_FS = 32'hC000_0100;
  localparam logic [31:0] MSR_SEG_GS = 32'hC000_0101;
  localparam logic [23:0] MSR_IRQ_RANGE = 24'h00_0008;
  // abort reason codes
  localparam logic [31:0] CODE_GUEST_MSR = 32'h0000_0001;
  localparam logic [31:0] CODE_PTE = 32'h0000_0002;
  localparam logic [31:0] CODE_CORRUPT = 32'h0000_0003;
  localparam logic [31:0] CODE_HOST_MSR = 32'h0000_0004;
  localparam logic [31:0] CODE_MC = 32'h0000_0005;
  localparam logic [31:0] CODE_WIDE = 32'h0000_0006;
  localparam logic [15:0] SEC_ABORT = 16'h000D;
  localparam logic [15:0] SEC_MC = 16'h000C;
  localparam logic [15:0] VCPU_TAG_ZERO = 16'h0000;
  localparam logic [31:0] REASON_RESET = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_PTE, ST_MSR, ST_DONE, ST_ABORT, ST_HALT, ST_SHUT
  } gxa_state_type;
endpackage : gxa_pkg

//--- rtl/gxa_exit.sv
// Behaviour
// - load ip, sp; flags cleared, bit1 set
// - ext paging only if bit5, not wide
// - check entries if paging new or base changes
// - never check entries without ext paging
// - bad entry aborts, else latch entries
// - active, no shadow, no pending debug
// - nmi exit sets nmi blocking only
// - tag off: invalidate tag zero, all contexts
// - every exit clears address monitoring
// - load list entries in order, count
// - segment-base or irq-range index fails
// - reserved bits, mgmt-only, barred, fault fail
// - flush-demanding load flushes cached translations
// - abort writes no structure data back
// - abort writes nonzero code at offset 4
// - reason codes one to six
// - secure shutdown 000D, else bus cycle
// - abort shutdown left only by reset
// - before-exit only if nothing loaded
// - before: shutdown or fault or exit
// - after: host fault or shutdown
// - machine check may abort, code 5
// - list loading only after host loads
`timescale 1ns/1ps
module gxa_exit #(
  parameter logic [63:0] PTE_RSVD = 64'hFFF0_0000_0000_01E6
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_exit_req,
  input wire logic i_exit_nmi,
  input wire logic [63:0] i_host_ip,
  input wire logic [63:0] i_host_sp,
  input wire logic [63:0] i_host_cr4,
  input wire logic i_host_wide,
  input wire logic [63:0] i_host_page_base,
  input wire logic [63:0] i_cur_page_base,
  input wire logic i_paging_before,
  input wire logic i_wide_before,
  input wire logic i_guest_msr_fail,
  input wire logic i_corrupt,
  input wire logic i_vcpu_tag_en,
  input wire logic i_secure_launch,
  input wire logic i_end_in_mgmt,
  input wire logic i_mc_event,
  input wire logic i_guest_mce,
  input wire logic i_host_mce,
  input wire logic [31:0] i_exc_bitmap,
  input wire logic i_monitor_arm,
  output logic o_pte_req,
  output logic [1:0] o_pte_idx,
  output logic [63:0] o_pte_addr,
  input wire logic i_pte_ack,
  input wire logic [63:0] i_pte_data,
  output logic o_msr_req,
  output logic [31:0] o_msr_num,
  input wire logic i_msr_ack,
  input wire logic [127:0] i_msr_entry,
  input wire logic i_msr_mgmt_only,
  input wire logic i_msr_barred,
  input wire logic i_msr_wr_fault,
  input wire logic i_msr_flush,
  output logic o_msr_wr,
  output logic [31:0] o_msr_index,
  output logic [63:0] o_msr_data,
  output logic [63:0] o_instr_pointer,
  output logic [63:0] o_stack_pointer,
  output logic [63:0] o_flags_word,
  output logic [255:0] o_pte_regs,
  output logic o_pte_load,
  output logic o_active,
  output logic o_shadow_block,
  output logic o_pend_dbg,
  output logic o_nmi_block,
  input wire logic i_nmi_unblock,
  output logic o_inval,
  output logic [15:0] o_inval_tag,
  output logic o_tlb_flush,
  output logic o_monitor_armed,
  output logic o_exit_done,
  output logic o_abort_wr,
  output logic [31:0] o_abort_code,
  output logic o_special_cycle,
  output logic o_sec_shutdown,
  output logic [15:0] o_sec_code,
  output logic o_abort_shutdown,
  output logic o_shutdown,
  output logic o_mc_guest_fault,
  output logic o_mc_exit,
  output logic o_mc_host_fault,
  input wire logic [4:0] i_wake_evt,
  output logic [4:0] o_wake_evt
);
  gxa_pkg::gxa_state_type state;
  logic [1:0] mc_policy;
  logic [31:0] msr_count;
  logic [31:0] reason;
  logic [31:0] code;
  logic [31:0] msr_cnt;
  logic [63:0] pte_buf [4];
  logic wr_pend;
  logic [7:0] wr_addr;
  logic host_loaded;
  logic mc_pend;
  logic flush_pend;
  logic addr_ok;
  logic in_exit;
  logic pae_host;
  logic need_pte;
  logic load_bad;
  logic [31:0] load_code;
  logic pte_bad;
  logic msr_bad;
  logic [31:0] ent_idx;
  logic mc_now;

  // bus slave: zero wait, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign addr_ok = i_hsel && i_htrans[1] && i_hready;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && i_hwrite;
      wr_addr <= i_haddr[7:0];
    end
  end

  // read data prepared at address phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_ok && !i_hwrite) begin
      case (i_haddr[7:0])
        gxa_pkg::ADDR_CTRL: o_hrdata <= {30'h0000_0000, mc_policy};
        gxa_pkg::ADDR_ABORT: o_hrdata <= reason;
        gxa_pkg::ADDR_COUNT: o_hrdata <= msr_count;
        gxa_pkg::ADDR_STATUS: begin
          o_hrdata <= 32'h0000_0000;
          o_hrdata[gxa_pkg::ST_BUSY_BIT] <= in_exit;
          o_hrdata[gxa_pkg::ST_MON_BIT] <= o_monitor_armed;
          o_hrdata[gxa_pkg::ST_NMI_BIT] <= o_nmi_block;
          o_hrdata[gxa_pkg::ST_SHUT_BIT] <= o_shutdown;
          o_hrdata[gxa_pkg::ST_HALT_BIT] <= o_abort_shutdown;
        end
        default: o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      mc_policy <= gxa_pkg::CTRL_RESET;
      msr_count <= 32'h0000_0000;
    end else if (wr_pend) begin
      if (wr_addr == gxa_pkg::ADDR_CTRL) begin
        mc_policy <= i_hwdata[gxa_pkg::CTRL_POL_LSB +: 2];
      end
      if (wr_addr == gxa_pkg::ADDR_COUNT) begin
        msr_count <= i_hwdata;
      end
    end
  end

  // hardware write beats a software clear in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      reason <= gxa_pkg::REASON_RESET;
    end else if (state == gxa_pkg::ST_ABORT) begin
      reason <= code;
    end else if (wr_pend && wr_addr == gxa_pkg::ADDR_ABORT) begin
      reason <= i_hwdata;
    end
  end

  assign in_exit = state == gxa_pkg::ST_LOAD || state == gxa_pkg::ST_PTE ||
                   state == gxa_pkg::ST_MSR;
  assign pae_host = i_host_cr4[gxa_pkg::CR4_EXT_BIT] && !i_host_wide;
  // checking only when required keeps the optional case out
  assign need_pte = pae_host && (!i_paging_before ||
                    i_host_page_base != i_cur_page_base);
  assign mc_now = in_exit && i_mc_event;

  // any one cause may be reported; first match wins
  always_comb begin
    load_bad = 1'b1;
    load_code = gxa_pkg::CODE_CORRUPT;
    if (i_corrupt) begin
      load_code = gxa_pkg::CODE_CORRUPT;
    end else if (i_guest_msr_fail) begin
      load_code = gxa_pkg::CODE_GUEST_MSR;
    end else if (i_wide_before && !i_host_wide) begin
      load_code = gxa_pkg::CODE_WIDE;
    end else begin
      load_bad = 1'b0;
    end
  end

  assign pte_bad = i_pte_data[0] && ((i_pte_data & PTE_RSVD) != 64'h0000_0000_0000_0000);
  assign ent_idx = i_msr_entry[31:0];
  assign msr_bad = ent_idx == gxa_pkg::MSR_SEG_FS || ent_idx == gxa_pkg::MSR_SEG_GS ||
                   ent_idx[31:8] == gxa_pkg::MSR_IRQ_RANGE ||
                   i_msr_entry[63:32] != 32'h0000_0000 ||
                   (i_msr_mgmt_only && !i_end_in_mgmt) ||
                   i_msr_barred || i_msr_wr_fault;

  assign o_pte_req = state == gxa_pkg::ST_PTE;
  assign o_pte_addr = {i_host_page_base[63:5], o_pte_idx, 3'h0};
  assign o_msr_req = state == gxa_pkg::ST_MSR && msr_cnt != msr_count;
  assign o_msr_num = msr_cnt;
  assign o_inval_tag = gxa_pkg::VCPU_TAG_ZERO;
  // events are swallowed while halted
  assign o_wake_evt = o_abort_shutdown ? 5'h00 : i_wake_evt;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_nmi_block <= 1'b0;
    end else if (state == gxa_pkg::ST_LOAD && !load_bad && !mc_now && i_exit_nmi) begin
      o_nmi_block <= 1'b1;
    end else if (i_nmi_unblock) begin
      o_nmi_block <= 1'b0;
    end
  end

  // clearing on exit wins over a new arm
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_monitor_armed <= 1'b0;
    end else if (state == gxa_pkg::ST_LOAD) begin
      o_monitor_armed <= 1'b0;
    end else if (i_monitor_arm) begin
      o_monitor_armed <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state <= gxa_pkg::ST_IDLE;
      code <= gxa_pkg::CODE_CORRUPT;
      msr_cnt <= 32'h0000_0000;
      o_pte_idx <= 2'h0;
      host_loaded <= 1'b0;
      mc_pend <= 1'b0;
      flush_pend <= 1'b0;
      o_instr_pointer <= 64'h0000_0000_0000_0000;
      o_stack_pointer <= 64'h0000_0000_0000_0000;
      o_flags_word <= gxa_pkg::FLAGS_VAL;
      o_pte_regs <= '0;
      o_active <= 1'b1;
      o_shadow_block <= 1'b0;
      o_pend_dbg <= 1'b0;
      o_msr_index <= 32'h0000_0000;
      o_msr_data <= 64'h0000_0000_0000_0000;
      o_sec_code <= 16'h0000;
      o_abort_code <= 32'h0000_0000;
      o_abort_shutdown <= 1'b0;
      o_shutdown <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        pte_buf[k] <= 64'h0000_0000_0000_0000;
      end
      {o_pte_load, o_inval, o_tlb_flush, o_exit_done, o_abort_wr, o_special_cycle} <= 6'h00;
      {o_sec_shutdown, o_mc_guest_fault, o_mc_exit, o_mc_host_fault, o_msr_wr} <= 5'h00;
    end else begin
      {o_pte_load, o_inval, o_tlb_flush, o_exit_done, o_abort_wr, o_special_cycle} <= 6'h00;
      {o_sec_shutdown, o_mc_guest_fault, o_mc_exit, o_mc_host_fault, o_msr_wr} <= 5'h00;
      if (mc_now && mc_policy == gxa_pkg::POL_ABORT) begin
        code <= gxa_pkg::CODE_MC;
        state <= gxa_pkg::ST_ABORT;
      end else if (mc_now && mc_policy == gxa_pkg::POL_BEFORE && !host_loaded) begin
        // exit dropped, event taken in guest context
        state <= gxa_pkg::ST_IDLE;
        if (!i_guest_mce) begin
          if (i_secure_launch) begin
            o_sec_shutdown <= 1'b1;
            o_sec_code <= gxa_pkg::SEC_MC;
          end
          o_shutdown <= !i_secure_launch;
          state <= i_secure_launch ? gxa_pkg::ST_IDLE : gxa_pkg::ST_SHUT;
        end else if (!i_exc_bitmap[gxa_pkg::EXC_MC_BIT]) begin
          o_mc_guest_fault <= 1'b1;
        end else begin
          o_mc_exit <= 1'b1;
        end
      end else begin
        if (mc_now) begin
          // under after policy, or once host state is partly loaded, defer to completion
          mc_pend <= 1'b1;
        end
        case (state)
          gxa_pkg::ST_IDLE: begin
            if (i_exit_req) begin
              state <= gxa_pkg::ST_LOAD;
              host_loaded <= 1'b0;
              mc_pend <= 1'b0;
              flush_pend <= 1'b0;
              msr_cnt <= 32'h0000_0000;
              o_pte_idx <= 2'h0;
            end
          end
          gxa_pkg::ST_LOAD: begin
            if (load_bad) begin
              code <= load_code;
              state <= gxa_pkg::ST_ABORT;
            end else begin
              o_instr_pointer <= i_host_ip;
              o_stack_pointer <= i_host_sp;
              o_flags_word <= gxa_pkg::FLAGS_VAL;
              o_active <= 1'b1;
              o_shadow_block <= 1'b0;
              o_pend_dbg <= 1'b0;
              o_inval <= !i_vcpu_tag_en;
              host_loaded <= 1'b1;
              // list loading waits for register loads
              state <= need_pte ? gxa_pkg::ST_PTE : gxa_pkg::ST_MSR;
            end
          end
          gxa_pkg::ST_PTE: begin
            if (i_pte_ack) begin
              if (pte_bad) begin
                code <= gxa_pkg::CODE_PTE;
                state <= gxa_pkg::ST_ABORT;
              end else begin
                pte_buf[o_pte_idx] <= i_pte_data;
                o_pte_idx <= o_pte_idx + 2'h1;
                if (o_pte_idx == 2'h3) begin
                  // entries only become visible once all four pass
                  o_pte_regs <= {i_pte_data, pte_buf[2], pte_buf[1], pte_buf[0]};
                  o_pte_load <= 1'b1;
                  state <= gxa_pkg::ST_MSR;
                end
              end
            end
          end
          gxa_pkg::ST_MSR: begin
            if (msr_cnt == msr_count) begin
              state <= gxa_pkg::ST_DONE;
            end else if (i_msr_ack) begin
              if (msr_bad) begin
                code <= gxa_pkg::CODE_HOST_MSR;
                state <= gxa_pkg::ST_ABORT;
              end else begin
                o_msr_wr <= 1'b1;
                o_msr_index <= ent_idx;
                o_msr_data <= i_msr_entry[127:64];
                msr_cnt <= msr_cnt + 32'h0000_0001;
                if (i_msr_flush) begin
                  flush_pend <= 1'b1;
                end
              end
            end
          end
          gxa_pkg::ST_DONE: begin
            o_exit_done <= 1'b1;
            o_tlb_flush <= flush_pend;
            state <= gxa_pkg::ST_IDLE;
            if (mc_pend) begin
              if (i_host_mce) begin
                o_mc_host_fault <= 1'b1;
              end else if (i_secure_launch) begin
                o_sec_shutdown <= 1'b1;
                o_sec_code <= gxa_pkg::SEC_MC;
              end else begin
                o_shutdown <= 1'b1;
                state <= gxa_pkg::ST_SHUT;
              end
            end
          end
          gxa_pkg::ST_ABORT: begin
            // only the reason word leaves; structure data stays untouched
            o_abort_wr <= 1'b1;
            o_abort_code <= code;
            if (i_secure_launch) begin
              o_sec_shutdown <= 1'b1;
              o_sec_code <= gxa_pkg::SEC_ABORT;
            end else begin
              o_special_cycle <= 1'b1;
            end
            o_abort_shutdown <= 1'b1;
            state <= gxa_pkg::ST_HALT;
          end
          gxa_pkg::ST_HALT: state <= gxa_pkg::ST_HALT;
          gxa_pkg::ST_SHUT: state <= gxa_pkg::ST_SHUT;
          default: state <= gxa_pkg::ST_IDLE;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  flags_load_a: assert property (
    (state == gxa_pkg::ST_LOAD && !load_bad && !mc_now) |=>
      o_instr_pointer == $past(i_host_ip) && o_flags_word == gxa_pkg::FLAGS_VAL)
    else $error("host pointer or flags not loaded");
  pte_gate_a: assert property (
    state == gxa_pkg::ST_PTE |-> pae_host)
    else $error("entry check without ext paging");
  pte_must_a: assert property (
    (state == gxa_pkg::ST_LOAD && !load_bad && !mc_now && need_pte) |=> state == gxa_pkg::ST_PTE)
    else $error("required entry check skipped");
  pte_fail_a: assert property (
    (state == gxa_pkg::ST_PTE && i_pte_ack && pte_bad && !mc_now) |=>
      state == gxa_pkg::ST_ABORT ##1 reason == gxa_pkg::CODE_PTE)
    else $error("bad entry did not abort with code 2");
  nmi_set_a: assert property (
    (state == gxa_pkg::ST_LOAD && !load_bad && !mc_now && i_exit_nmi) |=> o_nmi_block)
    else $error("nmi exit left blocking clear");
  inval_a: assert property (
    (state == gxa_pkg::ST_LOAD && !load_bad && !mc_now) |=> o_inval == !$past(i_vcpu_tag_en))
    else $error("tag zero invalidate wrong");
  mon_clr_a: assert property (
    state == gxa_pkg::ST_LOAD |=> !o_monitor_armed)
    else $error("monitor left armed after exit");
  seg_fail_a: assert property (
    (o_msr_req && i_msr_ack && ent_idx == gxa_pkg::MSR_SEG_FS && !mc_now) |=> !o_msr_wr ##1 o_abort_wr)
    else $error("segment base entry was loaded");
  abort_code_a: assert property (
    o_abort_wr |-> reason != 32'h0000_0000 && reason == o_abort_code)
    else $error("abort wrote zero reason");
  sec_code_a: assert property (
    (state == gxa_pkg::ST_ABORT && i_secure_launch) |=> o_sec_shutdown && o_sec_code == gxa_pkg::SEC_ABORT)
    else $error("secure shutdown code wrong");
  halt_stay_a: assert property (
    o_abort_shutdown |=> o_abort_shutdown && o_wake_evt == 5'h00 [*2])
    else $error("left abort shutdown without reset");
endmodule : gxa_exit

//--- verification/gxa_list_model.sv
`timescale 1ns/1ps
module gxa_list_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_pte_req,
  input wire logic [1:0] i_pte_idx,
  input wire logic i_msr_req,
  input wire logic [31:0] i_msr_num,
  input wire logic i_slow,
  input wire logic i_bad_pte,
  input wire logic [2:0] i_kind,
  input wire logic i_flush,
  output logic o_pte_ack,
  output logic [63:0] o_pte_data,
  output logic o_msr_ack,
  output logic [127:0] o_msr_entry,
  output logic o_mgmt_only,
  output logic o_barred,
  output logic o_wr_fault,
  output logic o_msr_flush
);
  logic [3:0] wait_cnt;
  logic [63:0] junk;
  logic bad;
  logic [31:0] idx;
  logic due;
  // entry 1 carries the injected fault
  assign bad = o_msr_ack && i_msr_num == 32'h0000_0001;
  assign idx = !bad ? 32'h0000_0010 + i_msr_num : i_kind == 3'h1 ? 32'hC000_0100 : i_kind == 3'h2 ?
    32'hC000_0101 : i_kind == 3'h3 ? 32'h0000_0830 : 32'h0000_0011;
  // released lines walk, so a stale entry never looks valid
  assign o_pte_data = o_pte_ack ? {i_bad_pte, 35'h0, 14'h0001, i_pte_idx, 12'h001} : junk;
  assign o_msr_entry = o_msr_ack ? {32'hD000_0000, i_msr_num, 31'h0, bad && i_kind == 3'h4, idx} :
    {junk, ~junk};
  assign o_mgmt_only = bad && i_kind == 3'h5;
  assign o_barred = bad && i_kind == 3'h6;
  assign o_wr_fault = bad && i_kind == 3'h7;
  assign o_msr_flush = o_msr_ack && i_flush;
  assign due = wait_cnt >= (i_slow ? 4'h4 : 4'h0);
  always_ff @(posedge i_clk_sys) begin
    junk <= i_rst_b ? {junk[62:0], ~junk[63]} : 64'h0123_4567_89AB_CDEF;
    if (!i_rst_b || o_pte_ack || o_msr_ack) begin
      wait_cnt <= 4'h0;
      o_pte_ack <= 1'b0;
      o_msr_ack <= 1'b0;
    end else if (i_pte_req || i_msr_req) begin
      wait_cnt <= wait_cnt + 4'h1;
      o_pte_ack <= i_pte_req && due;
      o_msr_ack <= !i_pte_req && due;
    end
  end
endmodule : gxa_list_model

//--- verification/gxa_exit_tb_top.sv
`timescale 1ns/1ps
module gxa_exit_tb_top;
  logic i_clk_sys, i_rst_b, i_hsel, i_hwrite, i_hready, i_exit_req, i_exit_nmi, i_host_wide, i_paging_before;
  logic i_wide_before, i_guest_msr_fail, i_corrupt, i_vcpu_tag_en, i_secure_launch, i_end_in_mgmt, i_mc_event;
  logic i_guest_mce, i_host_mce, i_monitor_arm, i_nmi_unblock, i_pte_ack, i_msr_ack, i_msr_mgmt_only;
  logic i_msr_barred, i_msr_wr_fault, i_msr_flush, slow, bad_pte, flush, early, addr_bad;
  logic [1:0] i_htrans, o_pte_idx;
  logic [2:0] i_hsize, kind;
  logic [4:0] i_wake_evt, o_wake_evt;
  logic [15:0] o_inval_tag, o_sec_code;
  logic [31:0] i_haddr, i_hwdata, i_exc_bitmap, o_hrdata, o_msr_num, o_msr_index, o_abort_code, rd;
  logic [63:0] i_host_ip, i_host_sp, i_host_cr4, i_host_page_base, i_cur_page_base, i_pte_data, o_pte_addr;
  logic [63:0] o_msr_data, o_instr_pointer, o_stack_pointer, o_flags_word;
  logic [127:0] i_msr_entry;
  logic [255:0] o_pte_regs;
  logic o_hreadyout, o_hresp, o_pte_req, o_msr_req, o_msr_wr, o_pte_load, o_active, o_shadow_block, o_pend_dbg;
  logic o_nmi_block, o_inval, o_tlb_flush, o_monitor_armed, o_exit_done, o_abort_wr, o_special_cycle;
  logic o_sec_shutdown, o_abort_shutdown, o_shutdown, o_mc_guest_fault, o_mc_exit, o_mc_host_fault;
  int mismatches, n_tests, n_end, n_pte, n_inv, n_fl, n_ab, n_sp, n_sec, n_mcg, n_mce, n_mch, n_done;
  int code_x [12] = '{3, 1, 6, 2, 4, 4, 4, 4, 4, 4, 4, 5};
  logic [31:0] q [$];
  assign i_hready = o_hreadyout;
  gxa_exit i_dut (.*);
  gxa_list_model i_far (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_pte_req(o_pte_req), .i_pte_idx(o_pte_idx),
    .i_msr_req(o_msr_req), .i_msr_num(o_msr_num), .i_slow(slow), .i_bad_pte(bad_pte), .i_kind(kind),
    .i_flush(flush), .o_pte_ack(i_pte_ack), .o_pte_data(i_pte_data), .o_msr_ack(i_msr_ack),
    .o_msr_entry(i_msr_entry), .o_mgmt_only(i_msr_mgmt_only), .o_barred(i_msr_barred),
    .o_wr_fault(i_msr_wr_fault), .o_msr_flush(i_msr_flush));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // pulses stand a whole cycle, so the falling edge sees each once
  always @(negedge i_clk_sys) begin
    n_pte += o_pte_load === 1'b1;
    n_inv += o_inval === 1'b1;
    n_fl += o_tlb_flush === 1'b1;
    n_ab += o_abort_wr === 1'b1;
    n_sp += o_special_cycle === 1'b1;
    n_sec += o_sec_shutdown === 1'b1;
    n_mcg += o_mc_guest_fault === 1'b1;
    n_mce += o_mc_exit === 1'b1;
    n_mch += o_mc_host_fault === 1'b1;
    n_done += o_exit_done === 1'b1;
    n_end += (o_exit_done && !i_mc_event || o_abort_wr || o_mc_guest_fault || o_mc_exit || o_mc_host_fault ||
      o_sec_shutdown || o_shutdown) === 1'b1;
    if (o_msr_wr === 1'b1) begin
      q.push_back(o_msr_index);
      early |= o_instr_pointer !== i_host_ip;
    end
    // entries sit back to back from the new page base
    if (o_pte_req === 1'b1) addr_bad |= o_pte_addr !== i_host_page_base + {o_pte_idx, 3'h0};
  end
  task wrap_up;
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task tmo;
    mismatches++;
    wrap_up();
  endtask : tmo
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task rdy;
    int k;
    k = 0;
    do begin
      @(posedge i_clk_sys);
      k++;
      if (k > 50) tmo();
    end while (o_hreadyout !== 1'b1);
  endtask : rdy
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk_sys);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    i_haddr <= {24'h00_0000, a};
    rdy();
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= wd;
    rdy();
    rd = o_hrdata;
  endtask : bus
  task rst;
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
  endtask : rst
  task run;
    int k;
    @(posedge i_clk_sys);
    i_exit_req <= 1'b1;
    i_nmi_unblock <= 1'b0;
    {n_end, n_pte, n_inv, n_fl, n_ab, n_sp, n_sec, n_mcg, n_mce, n_mch, n_done} = '0;
    q.delete();
    {early, addr_bad} = 2'b00;
    @(posedge i_clk_sys);
    i_exit_req <= 1'b0;
    k = 0;
    while (n_end == 0) begin
      @(posedge i_clk_sys);
      k++;
      if (k > 200) tmo();
    end
    repeat (4) @(posedge i_clk_sys);
  endtask : run
  initial begin
    {i_hsel, i_hwrite, i_exit_req, i_exit_nmi, i_host_wide, i_paging_before, i_wide_before, i_guest_msr_fail,
      i_corrupt, i_vcpu_tag_en, i_secure_launch, i_end_in_mgmt, i_mc_event, i_guest_mce, i_host_mce,
      i_monitor_arm, i_nmi_unblock, i_rst_b, slow, bad_pte, flush, mismatches, n_tests} = '0;
    {i_htrans, kind, i_wake_evt, i_haddr, i_hwdata, i_exc_bitmap, i_host_cr4} = '0;
    i_hsize = 3'h2;
    i_host_ip = 64'h0000_7FFF_1234_5678;
    i_host_sp = 64'h0000_7FFF_0000_FF00;
    i_host_page_base = 64'h0000_0000_0012_3000;
    i_cur_page_base = 64'h0000_0000_0045_6000;
    rst();
    bus(0, gxa_pkg::ADDR_ABORT, '0);
    chk(rd, 0);
    bus(1, gxa_pkg::ADDR_ABORT, 32'hA5A5_5A5A);
    bus(0, gxa_pkg::ADDR_ABORT, '0);
    chk(rd, 32'hA5A5_5A5A);
    bus(1, gxa_pkg::ADDR_ABORT, '0);
    bus(0, 8'h40, '0);
    chk({o_hresp, rd}, 0);
    bus(1, gxa_pkg::ADDR_COUNT, 32'h0000_0002);
    i_monitor_arm <= 1'b1;
    i_host_cr4 <= 64'h0000_0000_0000_0020;
    i_exit_nmi <= 1'b1;
    flush <= 1'b1;
    @(posedge i_clk_sys);
    i_monitor_arm <= 1'b0;
    @(negedge i_clk_sys);
    chk(o_monitor_armed, 1);
    run();
    chk(o_instr_pointer, i_host_ip);
    chk(o_stack_pointer, i_host_sp);
    chk(o_flags_word, 64'h0000_0000_0000_0002);
    chk(n_pte, 1);
    for (int j = 0; j < 4; j++) chk(o_pte_regs[64*j +: 64], {36'h0, 14'h0001, 2'(j), 12'h001});
    chk({q.size(), q[0], q[1]}, {32'h2, 32'h0000_0010, 32'h0000_0011});
    chk(o_msr_data, 64'hD000_0000_0000_0001);
    chk(early, 0);
    chk(addr_bad, 0);
    chk({n_inv, o_inval_tag}, 48'h1_0000);
    chk(n_fl, 1);
    chk(o_nmi_block, 1);
    chk(o_monitor_armed, 0);
    chk({o_active, o_shadow_block, o_pend_dbg}, 3'b100);
    bus(1, gxa_pkg::ADDR_COUNT, 32'h0000_0001);
    i_host_wide <= 1'b1;
    i_exit_nmi <= 1'b0;
    i_vcpu_tag_en <= 1'b1;
    slow <= 1'b1;
    flush <= 1'b0;
    run();
    chk(n_pte, 0);
    chk({q.size(), n_inv, n_fl}, 96'h1_0000_0000_0000_0000);
    chk(o_nmi_block, 1);
    i_nmi_unblock <= 1'b1;
    i_host_wide <= 1'b0;
    i_paging_before <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      i_cur_page_base <= j ? 64'h0000_0000_0045_6000 : i_host_page_base;
      run();
      chk(n_pte, j);
      chk(o_nmi_block, 0);
    end
    // every abort needs a reset to leave shutdown
    for (int i = 0; i < 12; i++) begin
      rst();
      i_corrupt <= i == 0;
      i_guest_msr_fail <= i == 1;
      i_wide_before <= i == 2;
      i_host_cr4 <= {58'h0, i == 3, 5'h0};
      i_paging_before <= 1'b0;
      bad_pte <= i == 3;
      kind <= (i > 3 && i < 11) ? 3'(i - 3) : 3'h0;
      i_secure_launch <= i == 4;
      i_mc_event <= i == 11;
      i_wake_evt <= 5'h1F;
      bus(1, gxa_pkg::ADDR_COUNT, 32'h0000_0002);
      bus(1, gxa_pkg::ADDR_CTRL, i == 11 ? 32'h2 : 32'h1);
      chk(o_wake_evt, 5'h1F);
      run();
      chk({n_ab, o_abort_code}, {32'h1, 32'(code_x[i])});
      bus(0, gxa_pkg::ADDR_ABORT, '0);
      chk(rd, code_x[i]);
      chk({n_sp, n_sec}, i == 4 ? 64'h1 : 64'h1_0000_0000);
      if (i < 11) chk(q.size(), i > 3);
      if (i == 4) chk(o_sec_code, 16'h000D);
      if (i != 4) begin
        i_exit_req <= 1'b1;
        @(posedge i_clk_sys);
        i_exit_req <= 1'b0;
        repeat (8) @(posedge i_clk_sys);
        chk({o_abort_shutdown, o_wake_evt, n_done}, 38'h20_0000_0000);
      end
    end
    for (int i = 0; i < 5; i++) begin
      rst();
      i_wide_before <= 1'b0;
      i_host_mce <= i == 0;
      i_guest_mce <= i == 2 || i == 3;
      i_exc_bitmap <= i == 3 ? 32'h0004_0000 : 32'h0;
      i_secure_launch <= i == 4;
      i_mc_event <= 1'b1;
      bus(1, gxa_pkg::ADDR_CTRL, i < 2 ? 32'h1 : 32'h0);
      run();
      chk({n_mch > 0, o_shutdown, n_mcg > 0, n_mce > 0, n_sec > 0}, 64'h10 >> i);
      if (i == 0) chk(o_instr_pointer, i_host_ip);
      if (i == 4) chk(o_sec_code, 16'h000C);
    end
    wrap_up();
  end
endmodule : gxa_exit_tb_top
